// File: design/sto_regs.sv
// Synthesizer test, trim and block-enable override register bank
// Behaviour
// - TX correction boost forces VCO correction to 1111 in TX and cal-before-TX.
// - TX current boost forces VCO current trim to 11 in TX and cal-before-TX.
// - Override clear: cal field reads the internal calibration result.
// - Override set: written cal value replaces internal result for synthesizer.
// - Bit 7 reads calibration done; writing it sets the override.
// - Modulus select picks 64000 when 0, 65536 when 1.
// - Order field: 00 zero, 01 first, 10 second, 11 MASH 1-1-1.
// - Dithering applied only while dither enable bit is high.
// - Read-only VCO type bit: 0 constant gain, 1 single varactor.
// - Charge pump correction override at bit 5, value in bits 4:0.
// - VCO correction override at bit 6, value in bits 5:2.
// - Charge pump force-up bit 5 and force-down bit 4.
// - Bits 7 and 6 drive PFD reset and divider reset directly.
// - DC-offset-only at bit 3, DC current select in bits 2:0.
// - Divider trims for div3, div2, div1.5 in bits 5:4, 3:2, 1:0.
// - Open-loop enable at bit 5 opens the synthesizer loop.
// - First override register: eight enables, power amplifier at bit 4.
// - Second override register: DSM, mux, buffers, PLL reset at bit 0.
// - Lock detect enable acts directly, no override mode needed.
module sto_regs #(
  parameter int ADDR_W = 7 // Register address width
) (
  input wire logic MCLK_I, // Digital clock, 40 MHz
  input wire logic RESET_N_I, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] REG_ADDR_I, // Register address from SPI
  input wire logic [7:0] REG_WDATA_I, // Write data
  input wire logic REG_WR_I, // Write strobe, one cycle
  output logic [7:0] REG_RDATA_O, // Read data for the addressed register
  output logic REG_HIT_O, // Address falls inside this bank
  input wire logic TX_MODE_I, // Device is in TX mode
  input wire logic CAL_BEFORE_TX_I, // VCO calibration that precedes TX
  input wire logic [6:0] CAL_RESULT_I, // Internal VCO calibration result
  input wire logic CAL_DONE_I, // VCO calibration finished
  input wire logic VCO_TYPE_I, // VCO type strap
  output logic PFD_RST_O, // Phase detector reset to analog
  output logic FB_DIV_RST_O, // Feedback divider reset to analog
  output logic CP_FORCE_UP_O, // Charge pump force up
  output logic CP_FORCE_DN_O, // Charge pump force down
  output logic CP_DC_ONLY_O, // Charge pump DC offset only
  output logic [2:0] CP_DC_CURR_O, // Charge pump DC current select
  output logic [1:0] CP_GAIN_O, // Charge pump gain setting
  output logic CP_CORR_OVR_O, // Charge pump correction override
  output logic [4:0] CP_CORR_O, // Charge pump correction value
  output logic FB_DIV_HC_O, // Feedback divider high current
  output logic [1:0] DIV3_CURRENT_TRIM_O, // Divide-by-3 current trim
  output logic [1:0] DIV2_CURRENT_TRIM_O, // Divide-by-2 current trim
  output logic [1:0] DIV1_5_CURRENT_TRIM_O, // Divide-by-1.5 current trim
  output logic VCO_CORR_OVR_O, // VCO correction override
  output logic [3:0] VCO_CORR_O, // Effective VCO correction value
  output logic [1:0] VCO_CUR_O, // Effective VCO current trim
  output logic CAL_OVR_O, // Calibration override active
  output logic [6:0] CAL_VALUE_O, // Calibration word used by synthesizer
  output logic DS_DITHER_O, // Modulator dithering enabled
  output logic OPEN_LOOP_O, // Synthesizer loop open
  output logic [16:0] DS_MODULUS_O, // Modulus value
  output logic [1:0] DS_ORDER_O, // Modulator order
  output logic DS_RST_MODE_O, // Modulator reset mode
  output logic DS_RST_O, // Modulator reset
  output logic [7:0] BLK_OVR_A_O, // Block enable overrides, first group
  output logic [6:0] BLK_OVR_B_O, // DSM, mux, buffers, PLL reset overrides
  output logic LOCK_DET_EN_O // Lock detector enable
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] cp_test;
    logic [7:0] cp_trim;
    logic [7:0] div_trim;
    logic [7:0] vco_trim;
    logic cal_ovr;
    logic [6:0] cal_val;
    logic [7:0] syn_test;
    logic [7:0] blk_a;
    logic [7:0] blk_b;
  } sto_state_t;

  sto_state_t st_r;
  sto_state_t st_nxt;
  logic boost_phase;

  always_comb
  begin
    st_nxt = st_r;
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        sto_pkg::ADDR_CP_TEST: st_nxt.cp_test = REG_WDATA_I;
        sto_pkg::ADDR_CP_TRIM: st_nxt.cp_trim = REG_WDATA_I;
        sto_pkg::ADDR_DIV_TRIM: st_nxt.div_trim = REG_WDATA_I;
        sto_pkg::ADDR_VCO_TRIM: st_nxt.vco_trim = REG_WDATA_I;
        sto_pkg::ADDR_VCO_CAL:
        begin
          st_nxt.cal_ovr = REG_WDATA_I[sto_pkg::BIT_CAL_OVR];
          st_nxt.cal_val = REG_WDATA_I[6:0];
        end
        // Type bit is read-only, its storage is always written as zero
        sto_pkg::ADDR_SYN_TEST: st_nxt.syn_test = {REG_WDATA_I[7], 1'b0, REG_WDATA_I[5:0]};
        sto_pkg::ADDR_BLK_OVR_A: st_nxt.blk_a = REG_WDATA_I;
        sto_pkg::ADDR_BLK_OVR_B: st_nxt.blk_b = REG_WDATA_I;
        default: st_nxt = st_r;
      endcase
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      st_r.cp_test <= sto_pkg::RST_CP_TEST;
      st_r.cp_trim <= sto_pkg::RST_CP_TRIM;
      st_r.div_trim <= sto_pkg::RST_DIV_TRIM;
      st_r.vco_trim <= sto_pkg::RST_VCO_TRIM;
      st_r.cal_ovr <= sto_pkg::RST_VCO_CAL[7];
      st_r.cal_val <= sto_pkg::RST_VCO_CAL[6:0];
      st_r.syn_test <= sto_pkg::RST_SYN_TEST;
      st_r.blk_a <= sto_pkg::RST_BLK_OVR_A;
      st_r.blk_b <= sto_pkg::RST_BLK_OVR_B;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    REG_HIT_O = 1'b1;
    case (REG_ADDR_I)
      sto_pkg::ADDR_CP_TEST: REG_RDATA_O = st_r.cp_test;
      sto_pkg::ADDR_CP_TRIM: REG_RDATA_O = st_r.cp_trim;
      sto_pkg::ADDR_DIV_TRIM: REG_RDATA_O = st_r.div_trim;
      sto_pkg::ADDR_VCO_TRIM: REG_RDATA_O = st_r.vco_trim;
      // Done flag shares bit 7 with the override enable
      sto_pkg::ADDR_VCO_CAL: REG_RDATA_O = {CAL_DONE_I, CAL_VALUE_O};
      sto_pkg::ADDR_SYN_TEST: REG_RDATA_O = {st_r.syn_test[7], VCO_TYPE_I, st_r.syn_test[5:0]};
      sto_pkg::ADDR_BLK_OVR_A: REG_RDATA_O = st_r.blk_a;
      sto_pkg::ADDR_BLK_OVR_B: REG_RDATA_O = st_r.blk_b;
      default:
      begin
        REG_RDATA_O = 8'h00;
        REG_HIT_O = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Analog controls
  // ----------------------------------------
  // Straight wires, no gating, so analog sees the bit exactly
  assign PFD_RST_O = st_r.cp_test[7];
  assign FB_DIV_RST_O = st_r.cp_test[6];
  assign CP_FORCE_UP_O = st_r.cp_test[5];
  assign CP_FORCE_DN_O = st_r.cp_test[4];
  assign CP_DC_ONLY_O = st_r.cp_test[3];
  assign CP_DC_CURR_O = st_r.cp_test[2:0];
  assign CP_GAIN_O = st_r.cp_trim[7:6];
  assign CP_CORR_OVR_O = st_r.cp_trim[sto_pkg::BIT_CP_CORR_OVR];
  assign CP_CORR_O = st_r.cp_trim[4:0];
  assign FB_DIV_HC_O = st_r.div_trim[6];
  assign DIV3_CURRENT_TRIM_O = st_r.div_trim[5:4];
  assign DIV2_CURRENT_TRIM_O = st_r.div_trim[3:2];
  assign DIV1_5_CURRENT_TRIM_O = st_r.div_trim[1:0];

  assign boost_phase = TX_MODE_I | CAL_BEFORE_TX_I;

  sto_vco_boost u_vco_boost (
    .vco_trim_i(st_r.vco_trim),
    .corr_boost_en_i(st_r.div_trim[sto_pkg::BIT_TX_CORR_BOOST]),
    .boost_phase_i(boost_phase),
    .corr_ovr_o(VCO_CORR_OVR_O),
    .corr_o(VCO_CORR_O),
    .cur_o(VCO_CUR_O)
  );

  assign CAL_OVR_O = st_r.cal_ovr;
  assign CAL_VALUE_O = st_r.cal_ovr ? st_r.cal_val : CAL_RESULT_I;

  assign DS_DITHER_O = st_r.syn_test[sto_pkg::BIT_DS_DITHER];
  assign OPEN_LOOP_O = st_r.syn_test[sto_pkg::BIT_OPEN_LOOP];
  assign DS_MODULUS_O = st_r.syn_test[sto_pkg::BIT_DS_MODULUS] ? sto_pkg::DS_MODULUS_1
    : sto_pkg::DS_MODULUS_0;
  assign DS_ORDER_O = st_r.syn_test[3:2];
  assign DS_RST_MODE_O = st_r.syn_test[1];
  assign DS_RST_O = st_r.syn_test[0];

  assign BLK_OVR_A_O = st_r.blk_a;
  assign BLK_OVR_B_O = {st_r.blk_b[7], st_r.blk_b[5:0]};
  // Lock detect bypasses any override gating
  assign LOCK_DET_EN_O = st_r.blk_b[sto_pkg::BIT_LOCK_DET];
endmodule

// File: design/sto_pkg.sv
// Package: register map, fields and reset values of the synth test/override bank
package sto_pkg;
  localparam logic [6:0] ADDR_CP_TEST = 7'h57;
  localparam logic [6:0] ADDR_CP_TRIM = 7'h58;
  localparam logic [6:0] ADDR_DIV_TRIM = 7'h59;
  localparam logic [6:0] ADDR_VCO_TRIM = 7'h5A;
  localparam logic [6:0] ADDR_VCO_CAL = 7'h5B;
  localparam logic [6:0] ADDR_SYN_TEST = 7'h5C;
  localparam logic [6:0] ADDR_BLK_OVR_A = 7'h5D;
  localparam logic [6:0] ADDR_BLK_OVR_B = 7'h5E;
  // Undefined reset bits are taken as zero
  localparam logic [7:0] RST_CP_TEST = 8'h00;
  localparam logic [7:0] RST_CP_TRIM = 8'h80;
  localparam logic [7:0] RST_DIV_TRIM = 8'h80;
  localparam logic [7:0] RST_VCO_TRIM = 8'h83;
  localparam logic [7:0] RST_VCO_CAL = 8'h00;
  localparam logic [7:0] RST_SYN_TEST = 8'h0E;
  localparam logic [7:0] RST_BLK_OVR_A = 8'h00;
  localparam logic [7:0] RST_BLK_OVR_B = 8'h00;
  // Field positions
  localparam int BIT_TX_CORR_BOOST = 7;
  localparam int BIT_TX_CUR_BOOST = 7;
  localparam int BIT_VCO_CORR_OVR = 6;
  localparam int BIT_CP_CORR_OVR = 5;
  localparam int BIT_CAL_OVR = 7;
  localparam int BIT_DS_DITHER = 7;
  localparam int BIT_VCO_TYPE = 6;
  localparam int BIT_OPEN_LOOP = 5;
  localparam int BIT_DS_MODULUS = 4;
  localparam int BIT_LOCK_DET = 6;
  localparam int BIT_PA_OVR = 4;
  localparam int BIT_PLL_RST_OVR = 0;
  localparam logic [3:0] VCO_CORR_BOOST = 4'hF;
  localparam logic [1:0] VCO_CUR_BOOST = 2'h3;
  // Delta-sigma settings
  localparam logic [16:0] DS_MODULUS_0 = 17'h0FA00;
  localparam logic [16:0] DS_MODULUS_1 = 17'h10000;
  typedef enum logic [1:0] {DS_ORDER0, DS_ORDER1, DS_ORDER2, DS_MASH111} sto_ds_order_t;
endpackage

// File: design/sto_vco_boost.sv
// VCO current correction and trim with TX boost forcing
module sto_vco_boost (
  input wire logic [7:0] vco_trim_i, // VCO current trim register
  input wire logic corr_boost_en_i, // TX correction boost enable
  input wire logic boost_phase_i, // TX mode or calibration before TX
  output logic corr_ovr_o, // Correction override enable
  output logic [3:0] corr_o, // Effective correction value
  output logic [1:0] cur_o // Effective current trim
);
  always_comb
  begin
    corr_ovr_o = vco_trim_i[sto_pkg::BIT_VCO_CORR_OVR];
    corr_o = vco_trim_i[5:2];
    cur_o = vco_trim_i[1:0];
    if (corr_boost_en_i && boost_phase_i)
    begin
      corr_o = sto_pkg::VCO_CORR_BOOST;
    end
    if (vco_trim_i[sto_pkg::BIT_TX_CUR_BOOST] && boost_phase_i)
    begin
      cur_o = sto_pkg::VCO_CUR_BOOST;
    end
  end
endmodule

// File: testbench/sto_regs_assertions.sv
// Checker for the synth test/override register bank
module sto_regs_chk #(
  parameter int ADDR_W = 7 // Address width
) (
  input wire logic MCLK_I, // Clock
  input wire logic RESET_N_I, // Reset
  input wire logic [ADDR_W-1:0] REG_ADDR_I, // Address
  input wire logic [7:0] REG_WDATA_I, // Write data
  input wire logic REG_WR_I, // Write strobe
  input wire logic [7:0] REG_RDATA_O, // Read data
  input wire logic TX_MODE_I, // TX mode
  input wire logic CAL_BEFORE_TX_I, // Cal before TX
  input wire logic [6:0] CAL_RESULT_I, // Cal result
  input wire logic CAL_DONE_I, // Cal done
  input wire logic VCO_TYPE_I, // VCO type
  input wire logic PFD_RST_O, // PFD reset
  input wire logic FB_DIV_RST_O, // Divider reset
  input wire logic [3:0] VCO_CORR_O, // VCO correction
  input wire logic [1:0] VCO_CUR_O, // VCO current
  input wire logic CAL_OVR_O, // Cal override
  input wire logic [6:0] CAL_VALUE_O, // Cal value
  input wire logic [16:0] DS_MODULUS_O // Modulus
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Shadow boost enables, so the checks hold for as long as the bits stay set
  logic corr_boost_r;
  logic cur_boost_r;
  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
    begin
      corr_boost_r <= sto_pkg::RST_DIV_TRIM[sto_pkg::BIT_TX_CORR_BOOST];
      cur_boost_r <= sto_pkg::RST_VCO_TRIM[sto_pkg::BIT_TX_CUR_BOOST];
    end
    else if (REG_WR_I && REG_ADDR_I == 7'h59)
    begin
      corr_boost_r <= REG_WDATA_I[sto_pkg::BIT_TX_CORR_BOOST];
    end
    else if (REG_WR_I && REG_ADDR_I == 7'h5A)
    begin
      cur_boost_r <= REG_WDATA_I[sto_pkg::BIT_TX_CUR_BOOST];
    end
  end
  a_corr_boost: assert property (corr_boost_r && (TX_MODE_I || CAL_BEFORE_TX_I) |->
    VCO_CORR_O == 4'hF) else $error("correction not boosted");
  a_cur_boost: assert property (cur_boost_r && (TX_MODE_I || CAL_BEFORE_TX_I) |->
    VCO_CUR_O == 2'h3) else $error("current not boosted");
  a_cal_result: assert property (!CAL_OVR_O |-> CAL_VALUE_O == CAL_RESULT_I) else $error("cal result lost");
  a_cal_override: assert property (REG_WR_I && REG_ADDR_I == 7'h5B && REG_WDATA_I[7] |=>
    CAL_OVR_O && CAL_VALUE_O == $past(REG_WDATA_I[6:0])) else $error("cal override wrong");
  a_cal_done: assert property (REG_ADDR_I == 7'h5B |-> REG_RDATA_O[7] == CAL_DONE_I) else $error("done bit");
  a_ds_modulus: assert property (REG_ADDR_I == 7'h5C |->
    DS_MODULUS_O == (REG_RDATA_O[4] ? 17'h10000 : 17'h0FA00)) else $error("modulus wrong");
  a_vco_type: assert property (REG_ADDR_I == 7'h5C |-> REG_RDATA_O[6] == VCO_TYPE_I) else $error("vco type");
  a_analog_direct: assert property (REG_WR_I && REG_ADDR_I == 7'h57 |=>
    {PFD_RST_O, FB_DIV_RST_O} == $past(REG_WDATA_I[7:6])) else $error("analog resets wrong");
endmodule
bind sto_regs sto_regs_chk #(.ADDR_W(ADDR_W)) sto_regs_chk_inst (.*);

// File: testbench/sto_regs_tb.sv
// Self-checking testbench for the synth test/override register bank
module sto_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK_I = 1'b0, RESET_N_I = 1'b0, REG_WR_I = 1'b0, TX_MODE_I = 1'b0, CAL_BEFORE_TX_I = 1'b0;
  logic CAL_DONE_I = 1'b0, VCO_TYPE_I = 1'b0;
  logic [6:0] REG_ADDR_I = 7'h00, CAL_RESULT_I = 7'h00, CAL_VALUE_O, BLK_OVR_B_O;
  logic [7:0] REG_WDATA_I = 8'h00, REG_RDATA_O, BLK_OVR_A_O;
  logic REG_HIT_O, PFD_RST_O, FB_DIV_RST_O, CP_FORCE_UP_O, CP_FORCE_DN_O, CP_DC_ONLY_O, CP_CORR_OVR_O;
  logic FB_DIV_HC_O, VCO_CORR_OVR_O, CAL_OVR_O, DS_DITHER_O, OPEN_LOOP_O, DS_RST_MODE_O, DS_RST_O, LOCK_DET_EN_O;
  logic [1:0] CP_GAIN_O, DIV3_CURRENT_TRIM_O, DIV2_CURRENT_TRIM_O, DIV1_5_CURRENT_TRIM_O, VCO_CUR_O, DS_ORDER_O;
  logic [2:0] CP_DC_CURR_O;
  logic [3:0] VCO_CORR_O;
  logic [4:0] CP_CORR_O;
  logic [16:0] DS_MODULUS_O;
  int mismatches = 0;
  int tests_run = 0;
  localparam logic [7:0] RST_VAL [8] = '{8'h00, 8'h80, 8'h80, 8'h83, 8'h00, 8'h0E, 8'h00, 8'h00};
  // Undefined reset bits are don't-care
  localparam logic [7:0] RST_MASK [8] = '{8'h00, 8'hE0, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'hFF, 8'h00};
  sto_regs sto_regs_inst (.*);
  always #12.5 MCLK_I = ~MCLK_I;
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe stays high so writes can run back to back
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge MCLK_I);
    REG_WR_I = 1'b1;
    REG_ADDR_I = a;
    REG_WDATA_I = d;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(negedge MCLK_I);
    REG_WR_I = 1'b0;
    REG_ADDR_I = a;
    #1;
    check(REG_RDATA_O & m, e & m);
  endtask
  task automatic reset_and_check;
    RESET_N_I = 1'b0;
    repeat (3) @(negedge MCLK_I);
    RESET_N_I = 1'b1;
    for (int i = 0; i < 8; i++)
      rd(7'h57 + 7'(i), RST_VAL[i], RST_MASK[i]);
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    reset_and_check();
    rd(7'h5F, 8'h00);
    check(REG_HIT_O, 1'b0);
    wr(7'h57, 8'hB5);
    wr(7'h58, 8'hAA);
    wr(7'h59, 8'h5B);
    wr(7'h5A, 8'hD5);
    rd(7'h57, 8'hB5);
    check({PFD_RST_O, FB_DIV_RST_O, CP_FORCE_UP_O, CP_FORCE_DN_O, CP_DC_ONLY_O, CP_DC_CURR_O}, 8'hB5);
    check({CP_GAIN_O, CP_CORR_OVR_O, CP_CORR_O}, 8'hAA);
    check({FB_DIV_HC_O, DIV3_CURRENT_TRIM_O, DIV2_CURRENT_TRIM_O, DIV1_5_CURRENT_TRIM_O}, 7'h5B);
    check({VCO_CORR_OVR_O, VCO_CORR_O, VCO_CUR_O}, 7'h55);
    TX_MODE_I = 1'b1;
    #1;
    check({VCO_CORR_O, VCO_CUR_O}, 6'h17);
    wr(7'h59, 8'hDB);
    rd(7'h5A, 8'hD5);
    check({VCO_CORR_O, VCO_CUR_O}, 6'h3F);
    TX_MODE_I = 1'b0;
    CAL_BEFORE_TX_I = 1'b1;
    #1;
    check({VCO_CORR_O, VCO_CUR_O}, 6'h3F);
    CAL_BEFORE_TX_I = 1'b0;
    CAL_RESULT_I = 7'h2A;
    #1;
    check({VCO_CORR_O, VCO_CUR_O, CAL_VALUE_O}, 13'h0AAA);
    wr(7'h5B, 8'h85);
    rd(7'h5B, 8'h05);
    check({CAL_OVR_O, CAL_VALUE_O}, 8'h85);
    CAL_DONE_I = 1'b1;
    rd(7'h5B, 8'h85);
    wr(7'h5B, 8'h05);
    rd(7'h5B, 8'hAA);
    VCO_TYPE_I = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(7'h5C, {i[0], 1'b0, i[1], i[0], i[1:0], 2'b01});
      rd(7'h5C, {i[0], 1'b1, i[1], i[0], i[1:0], 2'b01});
      check({DS_DITHER_O, OPEN_LOOP_O, DS_ORDER_O, DS_RST_MODE_O, DS_RST_O}, {i[0], i[1], i[1:0], 2'b01});
      check(DS_MODULUS_O, i[0] ? 17'd65536 : 17'd64000);
    end
    wr(7'h5D, 8'h10);
    wr(7'h5E, 8'h41);
    wr(7'h5F, 8'hFF);
    rd(7'h5E, 8'h41);
    check({BLK_OVR_A_O, LOCK_DET_EN_O, BLK_OVR_B_O}, 16'h1081);
    CAL_DONE_I = 1'b0;
    CAL_RESULT_I = 7'h00;
    reset_and_check();
    report_and_stop();
  end
  initial
  begin
    #10us;
    mismatches++;
    report_and_stop();
  end
endmodule
